//--- uev_pkg.sv
// Constants and types for the UV EPROM read/program controller
package uev_pkg;
   localparam int CLK_PERIOD_NS = 50;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int TMR_W = 24;
   // Times in their own units
   localparam int ACCESS_NS = 450; // address_access_delay
   localparam int GATE_NS = 120; // gate_to_output_delay
   localparam int FLOAT_NS = 120; // output_float_delay
   localparam int SETUP_US = 2;
   localparam int HOLD_US = 2;
   localparam int RECOVERY_US = 2;
   localparam int PULSE_MS = 50;
   // Least times round up to whole cycles
   localparam logic [TMR_W-1:0] ACCESS_CYC =
      TMR_W'((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] FLOAT_CYC =
      TMR_W'((FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] SETUP_CYC =
      TMR_W'((SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] HOLD_CYC =
      TMR_W'((HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] RECOVERY_CYC =
      TMR_W'((RECOVERY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int PULSE_CYC_DEF = (PULSE_MS * 1000000) / CLK_PERIOD_NS;
   // Reset values
   localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
   localparam logic [DATA_W-1:0] DATA_RST = 8'hFF;
   typedef enum logic [3:0] {
      ST_IDLE, ST_RD_ACC, ST_FLOAT, ST_PG_SETUP, ST_PG_PULSE,
      ST_PG_HOLD, ST_PG_RECOV, ST_VF_ACC
   } uev_state_t;
endpackage : uev_pkg

//--- uev_tmr_if.sv
// Interval timer hookup between controller and timer
`timescale 1ns/10ps
interface uev_tmr_if;
   import uev_pkg::*;
   logic start;
   logic [TMR_W-1:0] len;
   logic expired;
   modport ctl (output start, output len, input expired);
   modport tmr (input start, input len, output expired);
endinterface : uev_tmr_if

//--- uev_timer.sv
// Down-counting interval timer for pin phase lengths
`timescale 1ns/10ps
module uev_timer
   import uev_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   uev_tmr_if.tmr t
);
   logic [TMR_W-1:0] cnt_r;
   logic [TMR_W-1:0] cnt_nxt;

   // Load on start, else count down to zero
   assign cnt_nxt = t.start ? t.len :
                    (cnt_r != '0) ? cnt_r - TMR_W'(1) : cnt_r;
   // Last cycle of the loaded interval
   assign t.expired = (cnt_r == TMR_W'(1));

   // Counter register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule : uev_timer

//--- uev_ctrl.sv
// Pin-level read and program controller for a 4Kx8 UV EPROM
`timescale 1ns/10ps
module uev_ctrl
   import uev_pkg::*;
#(
   parameter int PULSE_CYC = PULSE_CYC_DEF
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_read,
   input wire logic req_prog,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_data,
   output logic ready_r,
   output logic done_r,
   output logic verify_fail_r,
   output logic [DATA_W-1:0] rd_data_r,
   output logic [ADDR_W-1:0] address_lines_r,
   input wire logic [DATA_W-1:0] data_pins_in,
   output logic [DATA_W-1:0] data_pins_out_r,
   output logic data_pins_oe_r,
   output logic chip_en_n_r,
   output logic out_en_n_r,
   output logic vpp_en_r
);
   localparam logic [TMR_W-1:0] PULSE_LEN = TMR_W'(PULSE_CYC);

   uev_state_t state_r;
   uev_state_t state_nxt;
   logic [ADDR_W-1:0] addr_nxt;
   logic [DATA_W-1:0] data_nxt;
   logic [DATA_W-1:0] rd_data_nxt;
   logic take_read;
   logic take_prog;
   logic leaving;
   logic sample_rd;
   logic sample_vf;
   logic fail_nxt;
   logic done_nxt;
   logic ce_n_nxt;
   logic oe_n_nxt;
   logic vpp_nxt;
   logic doe_nxt;
   logic [TMR_W-1:0] len_sel;

   uev_tmr_if tmr_bus ();

   uev_timer uev_timer_inst (
      .clk (clk),
      .rst_n (rst_n),
      .t (tmr_bus.tmr)
   );

   // Request acceptance in idle only; read wins a tie; any address
   assign take_read = (state_r == ST_IDLE) && req_read;
   assign take_prog = (state_r == ST_IDLE) && req_prog && !req_read;
   assign leaving = tmr_bus.expired && (state_r != ST_IDLE);
   assign sample_rd = leaving && (state_r == ST_RD_ACC);
   assign sample_vf = leaving && (state_r == ST_VF_ACC);

   // Phase sequencer
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (take_read) begin
               state_nxt = ST_RD_ACC;
            end else if (take_prog) begin
               state_nxt = ST_PG_SETUP;
            end
         end
         ST_RD_ACC: begin
            if (leaving) begin
               state_nxt = ST_FLOAT;
            end
         end
         ST_FLOAT: begin
            if (leaving) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_PG_SETUP: begin
            if (leaving) begin
               state_nxt = ST_PG_PULSE;
            end
         end
         ST_PG_PULSE: begin
            if (leaving) begin
               state_nxt = ST_PG_HOLD;
            end
         end
         ST_PG_HOLD: begin
            if (leaving) begin
               state_nxt = ST_PG_RECOV;
            end
         end
         ST_PG_RECOV: begin
            if (leaving) begin
               state_nxt = ST_VF_ACC;
            end
         end
         ST_VF_ACC: begin
            if (leaving) begin
               state_nxt = ST_FLOAT;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Phase length for the state being entered
   assign len_sel = (state_nxt == ST_RD_ACC) ? ACCESS_CYC :
                    (state_nxt == ST_VF_ACC) ? ACCESS_CYC :
                    (state_nxt == ST_FLOAT) ? FLOAT_CYC :
                    (state_nxt == ST_PG_SETUP) ? SETUP_CYC :
                    (state_nxt == ST_PG_PULSE) ? PULSE_LEN :
                    (state_nxt == ST_PG_HOLD) ? HOLD_CYC :
                    RECOVERY_CYC;
   assign tmr_bus.start = (state_nxt != state_r) && (state_nxt != ST_IDLE);
   assign tmr_bus.len = len_sel;

   // Pin levels per phase
   assign ce_n_nxt = !((state_nxt == ST_RD_ACC) || (state_nxt == ST_VF_ACC)
                       || (state_nxt == ST_PG_PULSE));
   assign oe_n_nxt = !((state_nxt == ST_RD_ACC)
                       || (state_nxt == ST_VF_ACC));
   assign vpp_nxt = (state_nxt == ST_PG_SETUP) || (state_nxt == ST_PG_PULSE)
                    || (state_nxt == ST_PG_HOLD);
   assign doe_nxt = vpp_nxt;
   assign addr_nxt = (take_read || take_prog) ? req_addr : address_lines_r;
   assign data_nxt = take_prog ? req_data : data_pins_out_r;
   assign rd_data_nxt = (sample_rd || sample_vf) ? data_pins_in : rd_data_r;
   assign fail_nxt = sample_vf ? (data_pins_in != data_pins_out_r)
                     : (take_read || take_prog) ? 1'b0 : verify_fail_r;
   assign done_nxt = leaving && (state_r == ST_FLOAT);

   // State and pin registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         chip_en_n_r <= 1'b1;
         out_en_n_r <= 1'b1;
         vpp_en_r <= 1'b0;
         data_pins_oe_r <= 1'b0;
         address_lines_r <= ADDR_RST;
         data_pins_out_r <= DATA_RST;
      end else begin
         state_r <= state_nxt;
         chip_en_n_r <= ce_n_nxt;
         out_en_n_r <= oe_n_nxt;
         vpp_en_r <= vpp_nxt;
         data_pins_oe_r <= doe_nxt;
         address_lines_r <= addr_nxt;
         data_pins_out_r <= data_nxt;
      end
   end

   // User-side result registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ready_r <= 1'b0;
         done_r <= 1'b0;
         verify_fail_r <= 1'b0;
         rd_data_r <= DATA_RST;
      end else begin
         ready_r <= (state_nxt == ST_IDLE);
         done_r <= done_nxt;
         verify_fail_r <= fail_nxt;
         rd_data_r <= rd_data_nxt;
      end
   end

   // Helper: cycles of the current program pulse
   logic [TMR_W-1:0] pw_cnt_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pw_cnt_r <= '0;
      end else begin
         pw_cnt_r <= (!chip_en_n_r && vpp_en_r) ? pw_cnt_r + TMR_W'(1) : '0;
      end
   end

   // Pulse ends after exactly the pulse length
   pulse_width_a: assert property (@(posedge clk) disable iff (!rst_n)
      ($rose(chip_en_n_r) && vpp_en_r) |-> (pw_cnt_r == PULSE_LEN))
      else $error("program pulse length wrong");

   // Data driven only with supply raised and output-enable high
   data_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
      data_pins_oe_r |-> (vpp_en_r && out_en_n_r))
      else $error("data driven outside programming");

   // Address and data steady during the pulse
   pin_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!chip_en_n_r && vpp_en_r && !$past(chip_en_n_r))
      |-> ($stable(address_lines_r) && $stable(data_pins_out_r)))
      else $error("address or data moved during pulse");

   // Chip-enable and output-enable stay high for 8 cycles after the supply drops
   supply_recov_a: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(vpp_en_r) |-> (out_en_n_r && chip_en_n_r) [*8])
      else $error("verify started before supply recovery");

   // Every program cycle is followed by a verify read
   verify_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(vpp_en_r) |-> ##[1:60] (!chip_en_n_r && !out_en_n_r))
      else $error("no verify read after programming");

   // Output-enable only on a selected, undriven read
   oe_select_a: assert property (@(posedge clk) disable iff (!rst_n)
      !out_en_n_r |-> (!chip_en_n_r && !data_pins_oe_r && !vpp_en_r))
      else $error("output enable asserted while deselected");

   // Output-enable joins chip-enable with no lag on reads
   oe_lag_a: assert property (@(posedge clk) disable iff (!rst_n)
      ($fell(chip_en_n_r) && !vpp_en_r) |-> !out_en_n_r)
      else $error("output enable lags chip enable");

   // One chip-enable pulse per programmed byte
   one_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
      ($rose(chip_en_n_r) && vpp_en_r) |-> chip_en_n_r [*8])
      else $error("second pulse within a program cycle");

   read_done_c: cover property (@(posedge clk) disable iff (!rst_n)
      take_read ##[1:30] done_r);
   verify_ok_c: cover property (@(posedge clk) disable iff (!rst_n)
      sample_vf && (data_pins_in == data_pins_out_r));
   verify_bad_c: cover property (@(posedge clk) disable iff (!rst_n)
      sample_vf && (data_pins_in != data_pins_out_r));
endmodule : uev_ctrl

//--- uev_mem_model.sv
// Pin-level model of the 4Kx8 UV erasable memory
`timescale 1ns/10ps
module uev_mem_model
   import uev_pkg::*;
(
   input wire logic clk,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] bus,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic vpp,
   output logic [DATA_W-1:0] q,
   output logic drv,
   output logic bad
);
   logic [DATA_W-1:0] mem [0:4095];
   logic [ADDR_W-1:0] pa;
   logic [DATA_W-1:0] pd;
   int acc;
   // Drives only in read or verify, floats otherwise
   assign drv = !ce_n && !oe_n && !vpp;
   // Wrong byte shown until the access time has run
   assign q = (acc >= int'(ACCESS_CYC) - 1) ? mem[addr] : ~mem[addr];
   // Erased state
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'hFF;
      end
      bad = 1'b0;
      acc = 0;
   end
   // Cycles of steady selection
   always @(posedge clk) begin
      acc <= drv ? acc + 1 : 0;
      if (vpp && !oe_n) begin
         bad <= 1'b1;
      end
   end
   // Capture at pulse start
   always @(negedge ce_n) begin
      pa = addr;
      pd = bus;
   end
   // Burn at pulse end; a chip-enable rise without supply burns nothing
   always @(posedge ce_n) begin
      if (vpp) begin
         if (pa !== addr || pd !== bus) begin
            bad = 1'b1;
         end
         mem[addr] = mem[addr] & bus;
      end
   end
endmodule : uev_mem_model

//--- uev_ctrl_tb_top.sv
// Self-checking bench for the UV EPROM controller
`timescale 1ns/10ps
module uev_ctrl_tb_top;
   import uev_pkg::*;
   localparam int PW = 20;
   localparam int LIMIT = 20000;
   // Cycles from acceptance to done for one program and verify
   localparam int PROG_LAT = int'(SETUP_CYC) + PW + int'(HOLD_CYC)
      + int'(RECOVERY_CYC) + int'(ACCESS_CYC) + int'(FLOAT_CYC);
   logic clk, rst_n, req_read, req_prog, ready_r, done_r, verify_fail_r;
   logic data_pins_oe_r, chip_en_n_r, out_en_n_r, vpp_en_r, drv, bad;
   logic [ADDR_W-1:0] req_addr, address_lines_r;
   logic [DATA_W-1:0] req_data, rd_data_r, data_pins_out_r, bus, q, last;
   int errors, samples_checked, cyc, lat, pulse;
   uev_ctrl #(.PULSE_CYC(PW)) uev_ctrl_inst (.clk(clk), .rst_n(rst_n),
      .req_read(req_read), .req_prog(req_prog), .req_addr(req_addr),
      .req_data(req_data), .ready_r(ready_r), .done_r(done_r),
      .verify_fail_r(verify_fail_r), .rd_data_r(rd_data_r),
      .address_lines_r(address_lines_r), .data_pins_in(bus),
      .data_pins_out_r(data_pins_out_r), .data_pins_oe_r(data_pins_oe_r),
      .chip_en_n_r(chip_en_n_r), .out_en_n_r(out_en_n_r),
      .vpp_en_r(vpp_en_r));
   uev_mem_model uev_mem_model_inst (.clk(clk), .addr(address_lines_r),
      .bus(bus), .ce_n(chip_en_n_r), .oe_n(out_en_n_r), .vpp(vpp_en_r),
      .q(q), .drv(drv), .bad(bad));
   // Wire level; a released bus shows the inverse of its last value
   assign bus = data_pins_oe_r ? data_pins_out_r : (drv ? q : ~last);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   // Timeout, pulse width and contention watch
   always @(posedge clk) begin
      last <= bus;
      cyc <= cyc + 1;
      if (vpp_en_r && !chip_en_n_r) begin
         pulse <= pulse + 1;
      end
      if (data_pins_oe_r && drv) begin
         check("contention", 1'b1, 1'b0);
      end
      if (cyc == LIMIT) begin
         errors++;
         results();
      end
   end
   // One request, held until taken, then wait for done
   task automatic request(input logic rd, input logic pg,
      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      req_read = rd;
      req_prog = pg;
      req_addr = a;
      req_data = d;
      while (ready_r !== 1'b1) begin
         @(posedge clk);
         #5;
      end
      @(posedge clk);
      #5;
      req_read = 1'b0;
      req_prog = 1'b0;
      lat = 0;
      while (done_r !== 1'b1 && lat < 2000) begin
         @(posedge clk);
         #5;
         lat++;
      end
   endtask : request
   task automatic t_reset();
      check("ce_n", chip_en_n_r, 1'b1);
      check("oe_n", out_en_n_r, 1'b1);
      check("vpp", vpp_en_r, 1'b0);
      check("rd", rd_data_r, 8'hFF);
      rst_n = 1'b1;
      @(posedge clk);
      #5;
      check("ready", ready_r, 1'b1);
      $display("test reset done");
   endtask : t_reset
   task automatic t_read_erased();
      request(1'b1, 1'b0, 12'hFFF, 8'h00);
      check("rd", rd_data_r, 8'hFF);
      check("lat", lat, int'(ACCESS_CYC) + int'(FLOAT_CYC));
      check("done", done_r, 1'b1);
      check("addr", address_lines_r, 12'hFFF);
      check("ce_n", chip_en_n_r, 1'b1);
      $display("test read erased done");
   endtask : t_read_erased
   task automatic t_burn();
      pulse = 0;
      request(1'b0, 1'b1, 12'h123, 8'hA5);
      check("pulse", pulse, PW);
      check("lat", lat, PROG_LAT);
      check("rd", rd_data_r, 8'hA5);
      check("vfail", verify_fail_r, 1'b0);
      check("addr", address_lines_r, 12'h123);
      check("dout", data_pins_out_r, 8'hA5);
      check("doe", data_pins_oe_r, 1'b0);
      request(1'b0, 1'b1, 12'h123, 8'h5A);
      check("rd", rd_data_r, 8'h00);
      check("vfail", verify_fail_r, 1'b1);
      request(1'b1, 1'b0, 12'h123, 8'h00);
      check("vfail", verify_fail_r, 1'b0);
      check("rd", rd_data_r, 8'h00);
      check("bad", bad, 1'b0);
      $display("test burn done");
   endtask : t_burn
   task automatic t_order();
      request(1'b0, 1'b1, 12'h800, 8'h0F);
      request(1'b0, 1'b1, 12'h001, 8'hF0);
      request(1'b1, 1'b0, 12'h800, 8'h00);
      check("rd", rd_data_r, 8'h0F);
      request(1'b1, 1'b0, 12'h001, 8'h00);
      check("rd", rd_data_r, 8'hF0);
      pulse = 0;
      request(1'b1, 1'b1, 12'h800, 8'h00);
      check("pulse", pulse, 0);
      check("rd", rd_data_r, 8'h0F);
      check("bad", bad, 1'b0);
      $display("test order done");
   endtask : t_order
   initial begin
      rst_n = 1'b0;
      req_read = 1'b0;
      req_prog = 1'b0;
      req_addr = 12'h000;
      req_data = 8'h00;
      last = 8'h00;
      errors = 0;
      samples_checked = 0;
      cyc = 0;
      pulse = 0;
      repeat (3) @(posedge clk);
      #5;
      t_reset();
      t_read_erased();
      t_burn();
      t_order();
      results();
   end
endmodule : uev_ctrl_tb_top
